/* hw/tio_pkg.sv */
// Constants for terminal input and output conditioning
package tio_pkg;

    // ------------------------------------------------------------
    // Clock and time units
    // ------------------------------------------------------------
    localparam int CLK_HZ         = 200_000_000;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;
    localparam int DELAY_STEP_MS  = 100;
    localparam int FILTER_STEP_MS = 2;
    localparam int DETERM_STEP_MS = 10;
    localparam int DELAY_STEP_CYC  = DELAY_STEP_MS * CYC_PER_MS;
    localparam int FILTER_STEP_CYC = FILTER_STEP_MS * CYC_PER_MS;
    localparam int DETERM_STEP_CYC = DETERM_STEP_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // Setting ranges and reset values
    // ------------------------------------------------------------
    localparam logic [9:0] DELAY_MAX = 10'd1000;
    localparam logic [9:0] DELAY_DEF = 10'd0;
    localparam logic [7:0] RESP_MAX  = 8'd200;
    localparam logic [7:0] RESP_DEF  = 8'd1;
    localparam logic [7:0] DET_MAX   = 8'd200;
    localparam logic [7:0] DET_DEF   = 8'd0;
    localparam logic [7:0] SEL_DEF   = 8'h00;

    // ------------------------------------------------------------
    // Source codes and operators
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_MAX          = 8'd63;
    localparam logic [7:0] CODE_COMB_FIRST   = 8'd33;
    localparam logic [7:0] CODE_COMB_LAST    = 8'd38;
    localparam logic [7:0] CODE_OPTION_BOARD = 8'd63;
    localparam logic [7:0] CODE_NONE         = 8'hFF;
    localparam logic [1:0] OP_AND = 2'h0;
    localparam logic [1:0] OP_OR  = 2'h1;
    localparam logic [1:0] OP_XOR = 2'h2;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [6:0] OFS_DELAY  = 7'h00;
    localparam logic [6:0] OFS_COMB   = 7'h10;
    localparam logic [6:0] OFS_RESP   = 7'h40;
    localparam logic [6:0] OFS_DET    = 7'h64;
    localparam logic [6:0] OFS_STATUS = 7'h68;
    localparam int NUM_DELAY = 4;
    localparam int NUM_COMB  = 6;
    localparam int NUM_RESP  = 9;
    localparam int SEL1_LSB  = 0;
    localparam int SEL2_LSB  = 8;
    localparam int OP_LSB    = 16;
    localparam int STAT_P5_BIT    = 6;
    localparam int STAT_RELAY_BIT = 7;
    localparam int STAT_IN_LSB    = 8;
    localparam int STAT_FW_BIT    = 16;
    localparam int STAT_MS_LSB    = 24;

endpackage

/* hw/settle_timer.sv */
// Level settling timer with separate rise and fall times
`timescale 1ns/1ps
module settle_timer #(
    parameter int W    = 1,
    parameter int CW   = 10,
    parameter int UNIT = 2
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [W-1:0]  raw,
    input  wire logic [CW-1:0] on_units,
    input  wire logic [CW-1:0] off_units,
    output logic      [W-1:0]  settled
);
    localparam int SW = (UNIT > 1) ? $clog2(UNIT) : 1;

    if (UNIT < 1 || W < 1 || CW < 1) begin : g_check
        $error("settle_timer: bad parameters");
    end

    logic [W-1:0]  prev;
    logic [SW-1:0] sub;
    logic [CW-1:0] units;

    wire           changed = raw != prev;
    wire           pending = raw != settled;
    wire [CW-1:0]  target  = (|raw) ? on_units : off_units;
    wire           take    = pending & ~changed & (units >= target);
    wire           sub_end = sub == SW'(UNIT - 1);

    // ------------------------------------------------------------
    // Count whole units while the new level holds
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev    <= '0;
            settled <= '0;
            sub     <= '0;
            units   <= '0;
        end else begin
            prev <= raw;
            if (!pending || changed) begin
                sub   <= '0;
                units <= '0;
            end else if (take) begin
                settled <= raw;
            end else if (sub_end) begin
                sub   <= '0;
                units <= units + CW'(1);
            end else begin
                sub <= sub + SW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_full_time;
        @(posedge clk) disable iff (!rstn)
        $changed(settled) |-> $past(take);
    endproperty
    a_full_time: assert property (p_full_time)
        else $error("settled level changed before full time");

    property p_restart;
        @(posedge clk) disable iff (!rstn)
        changed |=> (units == '0) && (sub == '0);
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer not restarted on input change");

endmodule

/* hw/terminal_io_conditioning.sv */
// Terminal conditioning: output delays, combined outputs, input filters
// What this block does
// - Transistor output five gets on and off delays, 0 to 100 s, 0.1 s steps.
// - Relay output gets independent on and off delays, 0 to 100 s, default 0.
// - Six combined outputs, each from two selected sources, default code 00.
// - Operator code 00 AND, 01 OR, 02 XOR per combined output; default AND.
// - Source codes use output assignment set, excluding combined codes 33-38.
// - Source code 63 and the no-function code are also rejected.
// - A filter count of zero acts as one 2 ms unit.
// - Forward run input has its own filter, same unit, range and default.
// - Multi-step selection waits a determination time, 0-200 x 10 ms.
`timescale 1ns/1ps
module terminal_io_conditioning #(
    parameter int DELAY_CYC  = tio_pkg::DELAY_STEP_CYC,
    parameter int FILTER_CYC = tio_pkg::FILTER_STEP_CYC,
    parameter int DETERM_CYC = tio_pkg::DETERM_STEP_CYC,
    parameter int MS_BITS    = 4
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic [6:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic [7:0]         multi_input,
    input  wire logic               forward_run_input,
    input  wire logic               p5_request,
    input  wire logic               relay_request,
    input  wire logic [63:0]        function_status,
    output logic                    transistor_output_five,
    output logic                    relay_output,
    output logic      [5:0]         combined_out,
    output logic      [7:0]         filtered_input,
    output logic                    forward_run_filtered,
    output logic      [MS_BITS-1:0] multi_step_select
);
    if (MS_BITS < 1 || MS_BITS > 8) begin : g_check
        $error("terminal_io_conditioning: MS_BITS must be 1 to 8");
    end
    // ------------------------------------------------------------
    // Settings storage
    // ------------------------------------------------------------
    logic [9:0] delay_set [tio_pkg::NUM_DELAY];
    logic [7:0] sel1      [tio_pkg::NUM_COMB];
    logic [7:0] sel2      [tio_pkg::NUM_COMB];
    logic [1:0] op        [tio_pkg::NUM_COMB];
    logic [7:0] resp      [tio_pkg::NUM_RESP];
    logic [7:0] det;
    logic       ack;
    logic [8:0] pin_s1;
    logic [8:0] pin_s2;
    logic [8:0] filt;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [6:0]  comb_off = avs_address - tio_pkg::OFS_COMB;
    wire [6:0]  resp_off = avs_address - tio_pkg::OFS_RESP;
    wire [1:0]  didx     = avs_address[3:2];
    wire [2:0]  cidx     = comb_off[4:2];
    wire [3:0]  ridx     = resp_off[5:2];
    wire        in_delay = avs_address[6:4] == tio_pkg::OFS_DELAY[6:4];
    wire        in_comb  = avs_address >= tio_pkg::OFS_COMB
                           && avs_address < tio_pkg::OFS_RESP - 7'h18;
    wire        in_resp  = avs_address >= tio_pkg::OFS_RESP
                           && avs_address < tio_pkg::OFS_DET;
    wire        is_det   = avs_address[6:2] == tio_pkg::OFS_DET[6:2];
    wire        is_stat  = avs_address[6:2] == tio_pkg::OFS_STATUS[6:2];
    wire        access   = avs_read | avs_write;
    wire        wr       = avs_write & ack;
    wire [31:0] status;
    wire [31:0] rd_val =
        in_delay ? {22'h0, delay_set[didx]} :
        in_comb  ? {14'h0, op[cidx], sel2[cidx], sel1[cidx]} :
        in_resp  ? {24'h0, resp[ridx]} :
        is_det   ? {24'h0, det} :
        is_stat  ? status : 32'h0;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] merged  = (rd_val & ~be_mask) | (avs_writedata & be_mask);
    wire [7:0]  m_sel1  = merged[tio_pkg::SEL1_LSB +: 8];
    wire [7:0]  m_sel2  = merged[tio_pkg::SEL2_LSB +: 8];
    wire [1:0]  m_op    = merged[tio_pkg::OP_LSB +: 2];
    function automatic logic sel_ok(input logic [7:0] c);
        return c <= tio_pkg::CODE_MAX
            && !(c >= tio_pkg::CODE_COMB_FIRST
                 && c <= tio_pkg::CODE_COMB_LAST)
            && c != tio_pkg::CODE_OPTION_BOARD
            && c != tio_pkg::CODE_NONE;
    endfunction
    wire sel1_ok = sel_ok(m_sel1);
    wire sel2_ok = sel_ok(m_sel2);
    assign avs_waitrequest = access & ~ack;

    // ------------------------------------------------------------
    // Bus answer and register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= access & ~ack;
            if (avs_read && !ack)
                avs_readdata <= rd_val;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < tio_pkg::NUM_DELAY; i++)
                delay_set[i] <= tio_pkg::DELAY_DEF;
            for (int i = 0; i < tio_pkg::NUM_COMB; i++) begin
                sel1[i] <= tio_pkg::SEL_DEF;
                sel2[i] <= tio_pkg::SEL_DEF;
                op[i]   <= tio_pkg::OP_AND;
            end
            for (int i = 0; i < tio_pkg::NUM_RESP; i++)
                resp[i] <= tio_pkg::RESP_DEF;
            det <= tio_pkg::DET_DEF;
        end else if (wr) begin
            if (in_delay && merged[9:0] <= tio_pkg::DELAY_MAX)
                delay_set[didx] <= merged[9:0];
            if (in_comb && sel1_ok)
                sel1[cidx] <= m_sel1;
            if (in_comb && sel2_ok)
                sel2[cidx] <= m_sel2;
            if (in_comb && m_op <= tio_pkg::OP_XOR)
                op[cidx] <= m_op;
            if (in_resp && merged[7:0] <= tio_pkg::RESP_MAX)
                resp[ridx] <= merged[7:0];
            if (is_det && merged[7:0] <= tio_pkg::DET_MAX)
                det <= merged[7:0];
        end
    end
    // ------------------------------------------------------------
    // Output delays
    // ------------------------------------------------------------
    settle_timer #(.W(1), .CW(10), .UNIT(DELAY_CYC)) u_p5 (
        .clk       (clk),
        .rstn      (rstn),
        .raw       (p5_request),
        .on_units  (delay_set[0]),
        .off_units (delay_set[1]),
        .settled   (transistor_output_five)
    );

    settle_timer #(.W(1), .CW(10), .UNIT(DELAY_CYC)) u_relay (
        .clk       (clk),
        .rstn      (rstn),
        .raw       (relay_request),
        .on_units  (delay_set[2]),
        .off_units (delay_set[3]),
        .settled   (relay_output)
    );

    // ------------------------------------------------------------
    // Combined outputs
    // ------------------------------------------------------------
    logic [5:0] next_combined;
    for (genvar i = 0; i < tio_pkg::NUM_COMB; i++) begin : g_comb
        wire a = function_status[sel1[i][5:0]];
        wire b = function_status[sel2[i][5:0]];
        assign next_combined[i] = (op[i] == tio_pkg::OP_AND) ? a & b :
                                  (op[i] == tio_pkg::OP_OR)  ? a | b :
                                  a ^ b;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            combined_out <= 6'h00;
        else
            combined_out <= next_combined;
    end
    // ------------------------------------------------------------
    // Input synchronisers and filters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1 <= 9'h000;
            pin_s2 <= 9'h000;
        end else begin
            pin_s1 <= {forward_run_input, multi_input};
            pin_s2 <= pin_s1;
        end
    end

    for (genvar i = 0; i < tio_pkg::NUM_RESP; i++) begin : g_filt
        wire [9:0] units = resp[i] == 8'h00 ? 10'd1 : {2'h0, resp[i]};
        settle_timer #(.W(1), .CW(10), .UNIT(FILTER_CYC)) u_filt (
            .clk       (clk),
            .rstn      (rstn),
            .raw       (pin_s2[i]),
            .on_units  (units),
            .off_units (units),
            .settled   (filt[i])
        );
    end

    assign filtered_input       = filt[7:0];
    assign forward_run_filtered = filt[8];
    // ------------------------------------------------------------
    // Multi-step determination
    // ------------------------------------------------------------
    wire [MS_BITS-1:0] ms_raw = filt[MS_BITS-1:0];

    settle_timer #(.W(MS_BITS), .CW(10), .UNIT(DETERM_CYC)) u_ms (
        .clk       (clk),
        .rstn      (rstn),
        .raw       (ms_raw),
        .on_units  ({2'h0, det}),
        .off_units ({2'h0, det}),
        .settled   (multi_step_select)
    );

    assign status = {8'(multi_step_select), 7'h0, forward_run_filtered,
                     filtered_input, relay_output, transistor_output_five,
                     combined_out};
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire       src_a0 = function_status[sel1[0][5:0]];
    wire       src_b0 = function_status[sel2[0][5:0]];
    wire [1:0] op0    = op[0];
    wire [7:0] sel1_0 = sel1[0];
    wire       fw_sync = pin_s2[8];
    wire       wr_c0   = wr && in_comb && cidx == 3'h0;

    property p_and;
        @(posedge clk) disable iff (!rstn)
        (op0 == tio_pkg::OP_AND && !src_a0) |=> !combined_out[0];
    endproperty
    a_and: assert property (p_and)
        else $error("AND combination wrong");
    property p_or;
        @(posedge clk) disable iff (!rstn)
        (op0 == tio_pkg::OP_OR && src_b0) |=> combined_out[0];
    endproperty
    a_or: assert property (p_or)
        else $error("OR combination wrong");
    property p_xor;
        @(posedge clk) disable iff (!rstn)
        (op0 == tio_pkg::OP_XOR && src_a0 == src_b0) |=> !combined_out[0];
    endproperty
    a_xor: assert property (p_xor)
        else $error("XOR combination wrong");
    property p_reject_comb;
        @(posedge clk) disable iff (!rstn)
        (wr_c0 && m_sel1 >= 8'd33 && m_sel1 <= 8'd38) |=> $stable(sel1_0);
    endproperty
    a_reject_comb: assert property (p_reject_comb)
        else $error("combined output code accepted as source");
    property p_reject_other;
        @(posedge clk) disable iff (!rstn)
        (wr_c0 && (m_sel1 == 8'd63 || m_sel1 == 8'hFF)) |=> $stable(sel1_0);
    endproperty
    a_reject_other: assert property (p_reject_other)
        else $error("option board or none code accepted as source");
    property p_p5_hold;
        @(posedge clk) disable iff (!rstn)
        (p5_request == transistor_output_five)
            |=> $stable(transistor_output_five);
    endproperty
    a_p5_hold: assert property (p_p5_hold)
        else $error("transistor output changed without request");
    property p_relay_hold;
        @(posedge clk) disable iff (!rstn)
        (relay_request == relay_output) |=> $stable(relay_output);
    endproperty
    a_relay_hold: assert property (p_relay_hold)
        else $error("relay output changed without request");
    sequence s_ms_steady;
        $past(ms_raw) == $past(ms_raw, 2)
            && multi_step_select == $past(ms_raw);
    endsequence
    property p_ms_latch;
        @(posedge clk) disable iff (!rstn)
        $changed(multi_step_select) |-> s_ms_steady;
    endproperty
    a_ms_latch: assert property (p_ms_latch)
        else $error("multi-step selection latched while changing");
    property p_fw_filter;
        @(posedge clk) disable iff (!rstn)
        $changed(forward_run_filtered) |->
            forward_run_filtered == $past(fw_sync)
            && $past(fw_sync) == $past(fw_sync, 2);
    endproperty
    a_fw_filter: assert property (p_fw_filter)
        else $error("forward run filter took unsteady level");
endmodule

/* verif/tio_field_switch.sv */
// Field wiring model: switch terminals with contact chatter
`timescale 1ns/1ps
module tio_field_switch (
    input  wire logic       clk,
    input  wire logic [8:0] cmd,
    input  wire logic [3:0] chatter,
    output logic      [8:0] term
);
    logic [8:0] last;
    logic [8:0] chg;
    logic [3:0] left;
    initial begin
        term = 9'h000;
        last = 9'h000;
        chg = 9'h000;
        left = 4'h0;
    end
    // Contacts bounce on changed terminals, then rest at the commanded level
    always @(posedge clk) begin
        if (cmd != last) begin
            last <= cmd;
            chg <= cmd ^ last;
            left <= chatter;
            term <= cmd;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
            term <= (left == 4'h1) ? last : term ^ chg;
        end
    end
endmodule

/* verif/terminal_io_conditioning_tb_top.sv */
// Testbench for terminal input and output conditioning
`timescale 1ns/1ps
module terminal_io_conditioning_tb_top;
    logic        clk;
    logic        rstn;
    logic [6:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [8:0]  cmd;
    logic [3:0]  chatter;
    logic [8:0]  term;
    logic        p5_request;
    logic        relay_request;
    logic [63:0] function_status;
    logic        transistor_output_five;
    logic        relay_output;
    logic [5:0]  combined_out;
    logic [7:0]  filtered_input;
    logic        forward_run_filtered;
    logic [3:0]  multi_step_select;
    logic [31:0] rd;
    logic [7:0]  bad_codes [8];
    int          mismatches;
    int          checks;

    terminal_io_conditioning #(.DELAY_CYC(4), .FILTER_CYC(3),
        .DETERM_CYC(5), .MS_BITS(4)) terminal_io_conditioning_i (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .multi_input(term[7:0]), .forward_run_input(term[8]),
        .p5_request(p5_request), .relay_request(relay_request),
        .function_status(function_status),
        .transistor_output_five(transistor_output_five),
        .relay_output(relay_output), .combined_out(combined_out),
        .filtered_input(filtered_input),
        .forward_run_filtered(forward_run_filtered),
        .multi_step_select(multi_step_select));

    tio_field_switch tio_field_switch_i (
        .clk(clk), .cmd(cmd), .chatter(chatter), .term(term));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [6:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int  n;
        logic w;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            w = avs_waitrequest;
            n++;
        end while (w !== 1'b0 && n < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (w !== 1'b0) begin
            mismatches++;
            test_done();
        end
    endtask

    function automatic logic [31:0] probe(input int w);
        case (w)
            0: probe = {31'h0, transistor_output_five};
            1: probe = {31'h0, relay_output};
            2: probe = {31'h0, forward_run_filtered};
            11: probe = {28'h0, multi_step_select};
            default: probe = {31'h0, filtered_input[w-3]};
        endcase
    endfunction

    // Cycles until a watched output shows val, one cycle of slack
    task automatic lat(input int w, input logic [31:0] val, input int exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (probe(w) !== val && n < 500);
        check({31'h0, n >= exp - 1 && n <= exp + 1}, 32'h1);
        if (n >= 500)
            test_done();
    endtask

    // Cycles where a watched output differs from val
    task automatic stays(input int w, input logic [31:0] val, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge clk);
            if (probe(w) !== val)
                bad++;
        end
        check(bad, 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        cmd = 9'h000;
        chatter = 4'h0;
        p5_request = 1'b0;
        relay_request = 1'b0;
        function_status = 64'h0000_0000_0000_1000;
        mismatches = 0;
        checks = 0;
        bad_codes = '{8'd33, 8'd34, 8'd35, 8'd36, 8'd37, 8'd38, 8'd63, 8'hFF};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 7'h10 + 7'(4 * i), 32'h0, 4'hF);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 7'h40 + 7'(4 * i), 32'h0, 4'hF);
            check(rd, 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 7'(4 * i), 32'h0, 4'hF);
            check(rd, 32'h0);
        end
        bus(1'b0, 7'h64, 32'h0, 4'hF);
        check(rd, 32'h0);
        bus(1'b0, 7'h70, 32'h0, 4'hF);
        check(rd, 32'h0);
        $display("test defaults done");
        bus(1'b1, 7'h10, 32'h0001_0C0B, 4'hF);
        foreach (bad_codes[k]) begin
            bus(1'b1, 7'h10, {14'h0, 2'h3, bad_codes[k], bad_codes[k]}, 4'hF);
            bus(1'b0, 7'h10, 32'h0, 4'hF);
            check(rd, 32'h0001_0C0B);
        end
        bus(1'b1, 7'h10, 32'h0002_3E20, 4'hF);
        bus(1'b1, 7'h10, 32'h0000_0505, 4'h2);
        bus(1'b0, 7'h10, 32'h0, 4'hF);
        check(rd, 32'h0002_0520);
        bus(1'b1, 7'h00, 32'd1000, 4'hF);
        bus(1'b1, 7'h00, 32'd1001, 4'hF);
        bus(1'b0, 7'h00, 32'h0, 4'hF);
        check(rd, 32'd1000);
        bus(1'b1, 7'h40, 32'd201, 4'hF);
        bus(1'b1, 7'h64, 32'd201, 4'hF);
        bus(1'b0, 7'h40, 32'h0, 4'hF);
        check(rd, 32'd1);
        bus(1'b0, 7'h64, 32'h0, 4'hF);
        check(rd, 32'd0);
        $display("test refusals done");
        for (int i = 0; i < 6; i++)
            bus(1'b1, 7'h10 + 7'(4 * i), {14'h0, 2'(i % 3), 8'(i + 40),
                8'(i + 1)}, 4'hF);
        for (int ab = 0; ab < 4; ab++) begin
            @(posedge clk);
            for (int i = 0; i < 6; i++) begin
                function_status[i + 1] <= ab[0];
                function_status[i + 40] <= ab[1];
            end
            repeat (3) @(negedge clk);
            for (int i = 0; i < 6; i++)
                check(combined_out[i], (i % 3 == 0) ? ab[0] & ab[1] :
                    (i % 3 == 1) ? ab[0] | ab[1] : ab[0] ^ ab[1]);
        end
        $display("test combined done");
        bus(1'b1, 7'h00, 32'd2, 4'hF);
        bus(1'b1, 7'h04, 32'd3, 4'hF);
        bus(1'b1, 7'h08, 32'd1, 4'hF);
        @(posedge clk);
        p5_request <= 1'b1;
        repeat (5) @(posedge clk);
        p5_request <= 1'b0;
        stays(0, 32'h0, 20);
        @(posedge clk);
        p5_request <= 1'b1;
        relay_request <= 1'b1;
        lat(0, 32'h1, 10);
        @(posedge clk);
        p5_request <= 1'b0;
        relay_request <= 1'b0;
        lat(0, 32'h0, 14);
        @(posedge clk);
        relay_request <= 1'b1;
        lat(1, 32'h1, 6);
        @(posedge clk);
        relay_request <= 1'b0;
        lat(1, 32'h0, 2);
        $display("test delays done");
        bus(1'b1, 7'h40, 32'd0, 4'hF);
        bus(1'b1, 7'h44, 32'd2, 4'hF);
        bus(1'b1, 7'h48, 32'd4, 4'hF);
        bus(1'b1, 7'h60, 32'd3, 4'hF);
        @(posedge clk);
        cmd[0] <= 1'b1;
        lat(3, 32'h1, 8);
        @(posedge clk);
        chatter <= 4'h3;
        cmd[1] <= 1'b1;
        lat(4, 32'h1, 14);
        @(posedge clk);
        chatter <= 4'h0;
        cmd[8] <= 1'b1;
        lat(2, 32'h1, 14);
        @(posedge clk);
        cmd[2] <= 1'b1;
        repeat (4) @(posedge clk);
        cmd[2] <= 1'b0;
        stays(5, 32'h0, 30);
        $display("test filters done");
        bus(1'b1, 7'h44, 32'd0, 4'hF);
        bus(1'b1, 7'h48, 32'd0, 4'hF);
        bus(1'b1, 7'h4C, 32'd0, 4'hF);
        bus(1'b1, 7'h64, 32'd2, 4'hF);
        @(posedge clk);
        cmd[3:0] <= 4'h0;
        repeat (40) @(posedge clk);
        check(multi_step_select, 32'h0);
        cmd[3:0] <= 4'h5;
        repeat (6) @(posedge clk);
        cmd[3:0] <= 4'h6;
        stays(11, 32'h0, 16);
        lat(11, 32'h6, 5);
        bus(1'b0, 7'h68, 32'h0, 4'hF);
        check(rd, 32'h0601_061B);
        $display("test multi step done");
        test_done();
    end
endmodule
